// ===== pcu_defines.svh
// Function
// - 16-bit base index, reset zero
// - 32-bit signed axis counter, reset zero
// - Motor source reloads axis counter from encoder
// - Each capture decrements 16-bit remaining count
// - Start with count above zero begins capture
// - Count zero sets done, clears start
// - Start with zero count refused, done cleared
// - Rewriting one while running keeps the run going, no restart
// - Option bit1 presets position after first capture
// - Option bit2 enables compare after first capture
// - Option bit3 launches command 50 when finished
// - Source field: off, aux, pulse, motor
// - Polarity field: normally open or closed
// - Trigger time field in milliseconds
`ifndef PCU_DEFINES_SVH
`define PCU_DEFINES_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define PCU_IDX_BASE 14'h0548
`define PCU_IDX_AXIS 14'h054A
`define PCU_IDX_REMAIN 14'h054C
`define PCU_IDX_CTRL 14'h054E
`define PCU_IDX_PRESET 14'h0600
`define PCU_IDX_CMPAMT 14'h0601
`define PCU_IDX_IRQ_STAT 14'h0602
`define PCU_IDX_IRQ_MASK 14'h0603
`define PCU_IDX_ARRAY 14'h2000

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PCU_RST_BASE 16'h0000
`define PCU_RST_AXIS 32'h0000_0000
`define PCU_RST_REMAIN 16'h0001
`define PCU_RST_CTRL 16'h2010

// ----------------------------------------------------------------
// Control word fields
// ----------------------------------------------------------------
`define PCU_CTRL_START 0
`define PCU_CTRL_PRESET 1
`define PCU_CTRL_CMPEN 2
`define PCU_CTRL_LAUNCH 3
`define PCU_CTRL_SRC 7:4
`define PCU_CTRL_POL 8
`define PCU_CTRL_TIME 15:12

// ----------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------
`define PCU_IRQ_CAPTURE 0
`define PCU_IRQ_DONE 1
`define PCU_IRQ_REFUSED 2
`define PCU_IRQ_W 3

// ----------------------------------------------------------------
// Sizes and timing
// ----------------------------------------------------------------
`define PCU_ARRAY_DEPTH 800
`define PCU_MOTION_CMD 8'h32
`define PCU_CLK_HZ 50000000
`define PCU_TIME_UNIT_HZ 1000
`define PCU_MS_CYCLES (`PCU_CLK_HZ / `PCU_TIME_UNIT_HZ)

`endif

// ===== pcu_pkg.sv
`default_nettype none
package pcu_pkg;
    // Capture source selection
    typedef enum logic [3:0] {
        PCU_SRC_OFF = 4'h0,
        PCU_SRC_AUX = 4'h1,
        PCU_SRC_PULSE = 4'h2,
        PCU_SRC_MOTOR = 4'h3
    } pcu_src_t;
endpackage : pcu_pkg
`default_nettype wire

// ===== pcu_capture.sv
`include "pcu_defines.svh"
`default_nettype none
module pcu_capture
    import pcu_pkg::*;
#(
    parameter int unsigned DEPTH = `PCU_ARRAY_DEPTH,
    parameter int unsigned MS_CYCLES = `PCU_MS_CYCLES
) (
    input wire logic CLK_I,
    input wire logic SRST_I,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [15:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    input wire logic TRIG_I,
    input wire logic [31:0] AUX_POS_I,
    input wire logic [31:0] PULSE_POS_I,
    input wire logic [31:0] MOTOR_POS_I,
    input wire logic CMP_ENABLED_I,
    output logic CAP_DONE_O,
    output logic POS_PRESET_O,
    output logic [31:0] POS_PRESET_VALUE_O,
    output logic CMP_ENABLE_SET_O,
    output logic [15:0] CMP_AMOUNT_O,
    output logic MOTION_CMD_O,
    output logic [7:0] MOTION_CMD_NUM_O,
    output logic IRQ_O
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wdat,
                                               input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = wdat[i*8 +: 8];
            end
        end
        return res;
    endfunction : lane_merge

    // ------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------
    logic [15:0] capture_array_base;
    logic [31:0] capture_axis_counter;
    logic [15:0] capture_remaining_count;
    logic [15:0] capture_control_word;
    logic [31:0] coordinate_preset_value;
    logic [15:0] compare_amount;
    logic [`PCU_IRQ_W-1:0] irq_stat;
    logic [`PCU_IRQ_W-1:0] irq_mask;
    logic [15:0] taken;
    logic [31:0] cap_array [DEPTH];
    logic [31:0] next_ctrl;
    logic [13:0] idx;
    logic wr;
    logic rd;
    logic wr_ctrl;
    logic start;
    logic running_write_ok;
    pcu_src_t src;
    logic trig_act;
    logic trig_filt;
    logic trig_filt_q;
    logic trig_pulse;
    logic [3:0] stable_ms;
    logic [31:0] ms_div;
    logic ms_tick;
    logic cap;
    logic cap_first;
    logic cap_last;
    logic [31:0] cap_value;
    logic [15:0] wr_slot;
    logic start_ok;
    logic start_refused;

    assign idx = ADR_I[15:2];
    assign wr = CYC_I && STB_I && WE_I && !ACK_O;
    assign rd = CYC_I && STB_I && !WE_I && !ACK_O;
    assign wr_ctrl = wr && (idx == `PCU_IDX_CTRL);
    assign start = capture_control_word[`PCU_CTRL_START];
    assign running_write_ok = !start;
    assign src = pcu_src_t'(capture_control_word[`PCU_CTRL_SRC]);
    assign next_ctrl = lane_merge({16'h0000, capture_control_word}, DAT_I, SEL_I);

    // Start requests seen on a control write
    assign start_ok = wr_ctrl && !start && next_ctrl[`PCU_CTRL_START]
                      && (capture_remaining_count != 16'h0000);
    assign start_refused = wr_ctrl && !start && next_ctrl[`PCU_CTRL_START]
                           && (capture_remaining_count == 16'h0000);

    // ------------------------------------------------------------
    // Wishbone slave: one wait cycle, unmapped reads give zero
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            ACK_O <= 1'b0;
        end else begin
            ACK_O <= CYC_I && STB_I && !ACK_O;
        end
    end

    // Read data mux
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            DAT_O <= 32'h0000_0000;
        end else if (rd) begin
            if (idx == `PCU_IDX_BASE) begin
                DAT_O <= {16'h0000, capture_array_base};
            end else if (idx == `PCU_IDX_AXIS) begin
                DAT_O <= capture_axis_counter;
            end else if (idx == `PCU_IDX_REMAIN) begin
                DAT_O <= {16'h0000, capture_remaining_count};
            end else if (idx == `PCU_IDX_CTRL) begin
                DAT_O <= {16'h0000, capture_control_word};
            end else if (idx == `PCU_IDX_PRESET) begin
                DAT_O <= coordinate_preset_value;
            end else if (idx == `PCU_IDX_CMPAMT) begin
                DAT_O <= {16'h0000, compare_amount};
            end else if (idx == `PCU_IDX_IRQ_STAT) begin
                DAT_O <= {{(32-`PCU_IRQ_W){1'b0}}, irq_stat};
            end else if (idx == `PCU_IDX_IRQ_MASK) begin
                DAT_O <= {{(32-`PCU_IRQ_W){1'b0}}, irq_mask};
            end else if (idx >= `PCU_IDX_ARRAY && 32'(idx - `PCU_IDX_ARRAY) < DEPTH) begin
                DAT_O <= cap_array[32'(idx - `PCU_IDX_ARRAY)];
            end else begin
                DAT_O <= 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    // Base index, held while capture runs
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            capture_array_base <= `PCU_RST_BASE;
        end else if (wr && idx == `PCU_IDX_BASE && running_write_ok) begin
            capture_array_base <= 16'(lane_merge({16'h0000, capture_array_base}, DAT_I, SEL_I));
        end
    end

    // Axis counter, follows the motor encoder when it is the source
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            capture_axis_counter <= `PCU_RST_AXIS;
        end else if (src == PCU_SRC_MOTOR) begin
            capture_axis_counter <= MOTOR_POS_I;
        end else if (wr && idx == `PCU_IDX_AXIS && running_write_ok) begin
            capture_axis_counter <= lane_merge(capture_axis_counter, DAT_I, SEL_I);
        end
    end

    // Preset value and compare amount
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            coordinate_preset_value <= 32'h0000_0000;
            compare_amount <= 16'h0000;
        end else if (wr && idx == `PCU_IDX_PRESET) begin
            coordinate_preset_value <= lane_merge(coordinate_preset_value, DAT_I, SEL_I);
        end else if (wr && idx == `PCU_IDX_CMPAMT) begin
            compare_amount <= 16'(lane_merge({16'h0000, compare_amount}, DAT_I, SEL_I));
        end
    end

    // Remaining count: software write wins over a capture decrement
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            capture_remaining_count <= `PCU_RST_REMAIN;
        end else if (wr && idx == `PCU_IDX_REMAIN) begin
            capture_remaining_count <= 16'(lane_merge({16'h0000, capture_remaining_count}, DAT_I, SEL_I));
        end else if (cap) begin
            capture_remaining_count <= capture_remaining_count - 16'h0001;
        end
    end

    // Control word with self-clearing start bit
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            capture_control_word <= `PCU_RST_CTRL;
        end else if (wr_ctrl) begin
            capture_control_word <= next_ctrl[15:0];
            if (start) begin
                capture_control_word[`PCU_CTRL_START] <= next_ctrl[`PCU_CTRL_START]
                    && !(cap && cap_last);
            end else begin
                capture_control_word[`PCU_CTRL_START] <= start_ok;
            end
        end else if (cap && cap_last) begin
            capture_control_word[`PCU_CTRL_START] <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Trigger recognition
    // ------------------------------------------------------------
    // Millisecond tick divider
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            ms_div <= 32'h0000_0000;
            ms_tick <= 1'b0;
        end else if (ms_div >= MS_CYCLES - 1) begin
            ms_div <= 32'h0000_0000;
            ms_tick <= 1'b1;
        end else begin
            ms_div <= ms_div + 32'h0000_0001;
            ms_tick <= 1'b0;
        end
    end

    assign trig_act = TRIG_I ^ capture_control_word[`PCU_CTRL_POL];

    // Active level must stand for the trigger time before it counts
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            stable_ms <= 4'h0;
            trig_filt <= 1'b0;
        end else if (!trig_act) begin
            stable_ms <= 4'h0;
            trig_filt <= 1'b0;
        end else if (stable_ms >= capture_control_word[`PCU_CTRL_TIME]) begin
            trig_filt <= 1'b1;
        end else if (ms_tick) begin
            stable_ms <= stable_ms + 4'h1;
        end
    end

    // Edge of the filtered trigger
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            trig_filt_q <= 1'b0;
        end else begin
            trig_filt_q <= trig_filt;
        end
    end
    assign trig_pulse = trig_filt && !trig_filt_q;

    // ------------------------------------------------------------
    // Capture engine
    // ------------------------------------------------------------
    // Source selection
    always_comb begin
        case (src)
            PCU_SRC_AUX: cap_value = AUX_POS_I;
            PCU_SRC_PULSE: cap_value = PULSE_POS_I;
            PCU_SRC_MOTOR: cap_value = capture_axis_counter;
            default: cap_value = 32'h0000_0000;
        endcase
    end

    assign cap = trig_pulse && start && (src != PCU_SRC_OFF)
                 && (capture_remaining_count != 16'h0000);
    assign cap_first = (taken == 16'h0000);
    assign cap_last = (capture_remaining_count == 16'h0001);
    assign wr_slot = capture_array_base + taken;

    // Array write, slots past the end are dropped
    always_ff @(posedge CLK_I) begin
        if (cap && 32'(wr_slot) < DEPTH) begin
            cap_array[32'(wr_slot)] <= cap_value;
        end
    end

    // Captures taken in this run
    always_ff @(posedge CLK_I) begin
        if (SRST_I || start_ok) begin
            taken <= 16'h0000;
        end else if (cap) begin
            taken <= taken + 16'h0001;
        end
    end

    // Done output
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            CAP_DONE_O <= 1'b0;
        end else if (cap && cap_last) begin
            CAP_DONE_O <= 1'b1;
        end else if (start_ok || start_refused) begin
            CAP_DONE_O <= 1'b0;
        end
    end

    // Side actions after first and last capture
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            POS_PRESET_O <= 1'b0;
            CMP_ENABLE_SET_O <= 1'b0;
            MOTION_CMD_O <= 1'b0;
        end else begin
            POS_PRESET_O <= cap && cap_first && capture_control_word[`PCU_CTRL_PRESET];
            CMP_ENABLE_SET_O <= cap && cap_first && capture_control_word[`PCU_CTRL_CMPEN]
                                && !CMP_ENABLED_I;
            MOTION_CMD_O <= cap && cap_last && capture_control_word[`PCU_CTRL_LAUNCH];
        end
    end

    assign POS_PRESET_VALUE_O = coordinate_preset_value;
    assign CMP_AMOUNT_O = compare_amount;
    assign MOTION_CMD_NUM_O = `PCU_MOTION_CMD;

    // ------------------------------------------------------------
    // Interrupts: sticky, write one to clear, set wins
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            irq_stat <= '0;
            irq_mask <= '0;
        end else begin
            if (wr && idx == `PCU_IDX_IRQ_MASK && SEL_I[0]) begin
                irq_mask <= DAT_I[`PCU_IRQ_W-1:0];
            end
            irq_stat <= (irq_stat & ~((wr && idx == `PCU_IDX_IRQ_STAT && SEL_I[0])
                                      ? DAT_I[`PCU_IRQ_W-1:0] : '0))
                        | {start_refused, cap && cap_last, cap};
        end
    end

    assign IRQ_O = |(irq_stat & irq_mask);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_last_done;
        @(posedge CLK_I) disable iff (SRST_I)
        (cap && cap_last && !wr) |=> (CAP_DONE_O && !start && capture_remaining_count == 16'h0000);
    endproperty
    a_last_done: assert property (p_last_done) else $error("done not set at last capture");

    property p_decrement;
        @(posedge CLK_I) disable iff (SRST_I)
        (cap && !(wr && idx == `PCU_IDX_REMAIN))
            |=> (capture_remaining_count == $past(capture_remaining_count) - 16'h0001);
    endproperty
    a_decrement: assert property (p_decrement) else $error("count not decremented");

    property p_idle_still;
        @(posedge CLK_I) disable iff (SRST_I)
        (!start && !wr) |=> $stable(capture_remaining_count) && $stable(taken);
    endproperty
    a_idle_still: assert property (p_idle_still) else $error("idle capture changed state");

    property p_refuse;
        @(posedge CLK_I) disable iff (SRST_I)
        start_refused |=> (!start && !CAP_DONE_O);
    endproperty
    a_refuse: assert property (p_refuse) else $error("start with zero count accepted");

    property p_start;
        @(posedge CLK_I) disable iff (SRST_I)
        start_ok |=> (start && !CAP_DONE_O && taken == 16'h0000);
    endproperty
    a_start: assert property (p_start) else $error("start not taken");

    property p_keep_one;
        @(posedge CLK_I) disable iff (SRST_I)
        (start && wr_ctrl && next_ctrl[`PCU_CTRL_START] && !cap) |=> start;
    endproperty
    a_keep_one: assert property (p_keep_one) else $error("start lost on rewrite");

    property p_motor;
        @(posedge CLK_I) disable iff (SRST_I)
        (src == PCU_SRC_MOTOR) |=> (capture_axis_counter == $past(MOTOR_POS_I));
    endproperty
    a_motor: assert property (p_motor) else $error("axis counter not reloaded");

    property p_preset;
        @(posedge CLK_I) disable iff (SRST_I)
        (cap && cap_first && capture_control_word[`PCU_CTRL_PRESET]) |=> POS_PRESET_O ##1 !POS_PRESET_O;
    endproperty
    a_preset: assert property (p_preset) else $error("preset pulse wrong");

    property p_launch;
        @(posedge CLK_I) disable iff (SRST_I)
        MOTION_CMD_O |-> ($past(cap) && CAP_DONE_O && MOTION_CMD_NUM_O == `PCU_MOTION_CMD);
    endproperty
    a_launch: assert property (p_launch) else $error("command launched out of turn");

    property p_cmp;
        @(posedge CLK_I) disable iff (SRST_I)
        CMP_ENABLE_SET_O |-> ($past(cap) && !$past(CMP_ENABLED_I));
    endproperty
    a_cmp: assert property (p_cmp) else $error("compare enable while enabled");

endmodule : pcu_capture
`default_nettype wire

// ===== pcu_axis_model.sv
`default_nettype none
// --------------------
// Encoders and trigger contact
// --------------------
module pcu_axis_model (
    input wire logic clk_i,
    input wire logic fire_i,
    input wire logic nc_i,
    output logic trig_o,
    output logic [31:0] aux_pos_o,
    output logic [31:0] pulse_pos_o,
    output logic [31:0] motor_pos_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] hold = 3'h0;
    logic [31:0] step = 32'h0000_0000;

    // Contact held for four cycles per request, axes move after it opens
    always_ff @(posedge clk_i) begin
        if (fire_i && hold == 3'h0) begin
            hold <= 3'h4;
        end else if (hold != 3'h0) begin
            hold <= hold - 3'h1;
            if (hold == 3'h1) begin
                step <= step + 32'h0000_0001; // Never moves while contact closed
            end
        end
    end

    // Closed-type contact idles high and opens on an event
    assign trig_o = (hold != 3'h0) ^ nc_i;
    // Three distinct position sources, motor one negative
    assign aux_pos_o = 32'h1000_0000 + step;
    assign pulse_pos_o = 32'h2000_0000 + step;
    assign motor_pos_o = 32'hFFFF_FF00 + step;
endmodule : pcu_axis_model
`default_nettype wire

// ===== testbench.sv
`default_nettype none
module testbench;
    import pcu_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, fire = 1'b0, nc = 1'b0, cmp_on = 1'b0;
    logic [15:0] adr = 16'h0000;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rd;
    logic trig, ack, done, pre, cmpset, mcmd, irq;
    logic [31:0] rdat, aux, pls, mot, pre_val;
    logic [15:0] cmp_amt;
    logic [7:0] mnum;
    int errors = 0, tests_run = 0, n_cmd = 0, n_pre = 0, n_cmp = 0, step = 0;

    // --------------------
    // Structure
    // --------------------
    pcu_capture #(.MS_CYCLES(4)) i_dut (.CLK_I(clk), .SRST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
        .ADR_I(adr), .SEL_I(4'hF), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .TRIG_I(trig),
        .AUX_POS_I(aux), .PULSE_POS_I(pls), .MOTOR_POS_I(mot), .CMP_ENABLED_I(cmp_on),
        .CAP_DONE_O(done), .POS_PRESET_O(pre), .POS_PRESET_VALUE_O(pre_val), .CMP_ENABLE_SET_O(cmpset),
        .CMP_AMOUNT_O(cmp_amt), .MOTION_CMD_O(mcmd), .MOTION_CMD_NUM_O(mnum), .IRQ_O(irq));
    pcu_axis_model i_axes (.clk_i(clk), .fire_i(fire), .nc_i(nc), .trig_o(trig), .aux_pos_o(aux),
        .pulse_pos_o(pls), .motor_pos_o(mot));

    // Clock and side-action pulse counters
    always #10 clk = ~clk;
    always @(posedge clk) begin
        if (mcmd === 1'b1) n_cmd++;
        if (pre === 1'b1) n_pre++;
        if (cmpset === 1'b1) n_cmp++;
    end

    // --------------------
    // Helpers
    // --------------------
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask : chk

    // Classic single Wishbone cycle, waits for ack under a bound
    task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) begin
            errors++;
            $display("BAD %0t no ack", $time);
        end
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task automatic rchk(input logic [15:0] a, input logic [31:0] e, input string what);
        wb(1'b0, a, 32'h0000_0000);
        chk(rd, e, what);
    endtask : rchk

    task automatic fire_trig();
        @(posedge clk);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        repeat (10) @(posedge clk);
        step++;
    endtask : fire_trig

    function automatic logic [31:0] pos(input int s, input int k);
        case (s)
            1: return 32'h1000_0000 + 32'(k);
            2: return 32'h2000_0000 + 32'(k);
            3: return 32'hFFFF_FF00 + 32'(k);
            default: return 32'h0000_0000;
        endcase
    endfunction : pos

    // --------------------
    // Scenarios
    // --------------------
    task automatic t_reset();
        rchk(16'h1520, 32'h0000_0000, "base reset");
        rchk(16'h1528, 32'h0000_0000, "axis reset");
        rchk(16'h1530, 32'h0000_0001, "remain reset");
        rchk(16'h1538, 32'h0000_2010, "ctrl reset");
        rchk(16'h0100, 32'h0000_0000, "unmapped read");
        chk({31'h0, done}, 32'h0000_0000, "done reset");
        $display("test reset finished");
    endtask : t_reset

    task automatic t_run();
        logic [31:0] e0, e1;
        wb(1'b1, 16'h1528, 32'h8000_0000);
        rchk(16'h1528, 32'h8000_0000, "axis lowest");
        wb(1'b1, 16'h1800, 32'h1234_5678);
        wb(1'b1, 16'h1804, 32'h0000_0321);
        chk(pre_val, 32'h1234_5678, "preset value");
        chk({16'h0, cmp_amt}, 32'h0000_0321, "compare amount");
        wb(1'b1, 16'h180C, 32'h0000_0002);
        wb(1'b1, 16'h1520, 32'h0000_0005);
        wb(1'b1, 16'h1530, 32'h0000_0002);
        wb(1'b1, 16'h1538, 32'h0000_001F);
        chk({31'h0, irq}, 32'h0000_0000, "irq idle");
        e0 = pos(1, step);
        fire_trig();
        e1 = pos(1, step);
        fire_trig();
        rchk(16'h8014, e0, "slot 5");
        rchk(16'h8018, e1, "slot 6");
        rchk(16'h1530, 32'h0000_0000, "remain end");
        rchk(16'h1538, 32'h0000_001E, "start cleared");
        chk({31'h0, done}, 32'h0000_0001, "done set");
        chk(32'(n_pre), 32'h0000_0001, "preset once");
        chk(32'(n_cmp), 32'h0000_0001, "compare once");
        chk(32'(n_cmd), 32'h0000_0001, "command once");
        chk({24'h0, mnum}, 32'h0000_0032, "command number");
        chk({31'h0, irq}, 32'h0000_0001, "irq raised");
        wb(1'b1, 16'h1808, 32'h0000_0007);
        chk({31'h0, irq}, 32'h0000_0000, "irq cleared");
        $display("test run finished");
    endtask : t_run

    task automatic t_stop();
        logic [31:0] e0;
        wb(1'b1, 16'h1530, 32'h0000_0003);
        wb(1'b1, 16'h1538, 32'h0000_0011);
        chk({31'h0, done}, 32'h0000_0000, "done dropped");
        wb(1'b1, 16'h1538, 32'h0000_0011);
        rchk(16'h1538, 32'h0000_0011, "still running");
        wb(1'b1, 16'h1520, 32'h0000_0009);
        rchk(16'h1520, 32'h0000_0005, "base locked");
        wb(1'b1, 16'h1528, 32'h0000_0001);
        rchk(16'h1528, 32'h8000_0000, "axis locked");
        e0 = pos(1, step);
        fire_trig();
        rchk(16'h8014, e0, "restart slot");
        rchk(16'h1530, 32'h0000_0002, "one taken");
        wb(1'b1, 16'h1538, 32'h0000_0010);
        rchk(16'h1538, 32'h0000_0010, "stopped");
        fire_trig();
        rchk(16'h1530, 32'h0000_0002, "idle trigger");
        $display("test stop finished");
    endtask : t_stop

    task automatic t_sources();
        logic [31:0] e;
        int s;
        cmp_on <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            s = (i == 0) ? 0 : i + 1;
            wb(1'b1, 16'h1520, 32'h0000_000A + 32'(i));
            wb(1'b1, 16'h1530, 32'h0000_0001);
            nc <= (s == 3);
            e = pos(s, step);
            wb(1'b1, 16'h1538, {23'h0, s == 3, 4'(s), 4'h5});
            fire_trig();
            if (s == 0) begin
                rchk(16'h1530, 32'h0000_0001, "source off");
                wb(1'b1, 16'h1538, 32'h0000_0000);
            end else begin
                rchk(16'h8028 + 16'(4 * i), e, "source value");
                rchk(16'h1530, 32'h0000_0000, "source remain");
            end
            if (s == 3) begin
                rchk(16'h1528, pos(s, step), "axis follows motor");
            end
        end
        chk(32'(n_cmp), 32'h0000_0001, "compare already on");
        wb(1'b1, 16'h1538, 32'h0000_0000);
        nc <= 1'b0;
        cmp_on <= 1'b0;
        $display("test sources finished");
    endtask : t_sources

    task automatic t_refuse();
        wb(1'b1, 16'h1538, 32'h0000_0011);
        rchk(16'h1538, 32'h0000_0010, "start refused");
        chk({31'h0, done}, 32'h0000_0000, "done cleared");
        wb(1'b0, 16'h1808, 32'h0000_0000);
        chk(rd & 32'h0000_0004, 32'h0000_0004, "refused flag");
        $display("test refuse finished");
    endtask : t_refuse

    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_run();
        t_stop();
        t_sources();
        t_refuse();
        report_and_stop();
    end

    // Watchdog
    initial begin
        #1_000_000;
        errors++;
        $display("BAD %0t timeout", $time);
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
